//--- sms_microstep.sv
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1: Sine amplitude is a signed 16-bit register, 1FFFh after reset.
// R2: Cosine amplitude is a signed 16-bit register, 2FFFh after reset.
// R3: Amplitudes above 3FFFh are limited to 3FFFh; usable down to C001h.
// R4: Iteration arithmetic is wide enough to see values leave the range.
// R5: An overflowing sample saturates to +16384 or -16384 by sign.
// R6: Back inside the limit, the wave continues normally, nothing held.
// R7: One 8-bit DC offset is added to both sine and cosine.
// R8: New sine = sine + cosine>>k; new cosine = cosine - new sine>>k.
// R9: Shift k comes from a 4-bit register, 4h after reset.
// R10: Steps per wave follow from k, roughly 2^(k+2)+2*2^k+k.
// R11: Small amplitude difference gives a linear ramp, smaller a constant.
// R12: Software keeps squared amplitudes plus offset within 16384 squared.
// R13: In sine-step mode both DACs show the absolute wave values.
// R14: Phase bit 0 follows sine sign, phase bit 2 cosine sign.
// R15: DAC magnitudes are 8 bits, so large k only slows motion.
// R16: Software selects sine-step by enable with pattern enable clear, step type 11, motor type 00.
// R17: With the select bit set, the sine wave drives all ten phase lines.
// R18: One iteration per ramp step pulse, in the pulse's direction.
`timescale 1ns/10ps
module sms_microstep (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire sms_pkg::sms_bus_t bus,
   input  wire logic              step_pulse,
   input  wire logic              step_dir,
   output logic [15:0]            rdata,
   output logic [7:0]             coil_a_level,
   output logic [7:0]             coil_b_level,
   output logic [9:0]             phase_out_lines
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Amplitude limited into the usable range before it seeds the oscillator
   function automatic logic [15:0] clip_amp(input logic [15:0] a);
      logic [15:0] r;
      r = a;
      if ($signed(a) > $signed(sms_pkg::SMS_AMP_MAX)) begin  // R3
         r = sms_pkg::SMS_AMP_MAX;
      end else if ($signed(a) < $signed(sms_pkg::SMS_AMP_MIN)) begin  // R3
         r = sms_pkg::SMS_AMP_MIN;
      end
      return r;
   endfunction

   // Absolute value scaled to the DAC; full scale is 16384
   function automatic logic [7:0] mag8(input logic [16:0] x);
      logic [16:0] a;
      logic [7:0]  r;
      a = x[16] ? (~x + 17'h00001) : x;  // R13
      r = a[13:6];
      if (a[16:6] > 11'h0FF) begin  // R15
         r = sms_pkg::SMS_DAC_FULL;
      end
      return r;
   endfunction

   sms_pkg::sms_state_t st;
   sms_pkg::sms_state_t next_st;
   sms_pkg::sms_wave_t  step_wave;
   logic                osc_en;
   logic                pat_en;
   logic                sel_wave;
   logic [1:0]          step_type;
   logic [1:0]          motor_type;
   logic                sine_mode;
   logic [16:0]         bias_ext;
   logic [16:0]         bias_s;
   logic [16:0]         bias_c;

   assign osc_en     = st.ctrl[sms_pkg::SMS_CTRL_OSC_EN];
   assign pat_en     = st.ctrl[sms_pkg::SMS_CTRL_PAT_EN];
   assign sel_wave   = st.ctrl[sms_pkg::SMS_CTRL_SEL];
   assign step_type  = st.ctrl[sms_pkg::SMS_CTRL_STEP_LSB +: 2];
   assign motor_type = st.ctrl[sms_pkg::SMS_CTRL_MOT_LSB +: 2];
   // Other step modes live elsewhere; only this combination is served here
   assign sine_mode  = osc_en && !pat_en                     // R16
                       && (step_type == sms_pkg::SMS_STEP_SINE)
                       && (motor_type == sms_pkg::SMS_MOTOR_SINE);

   // Offset counts in DAC steps, so one unit is 64 wave units
   assign bias_ext = {3'h0, st.bias, 6'h00};
   assign bias_s   = {st.wave.s[15], st.wave.s} + bias_ext;  // R7
   assign bias_c   = {st.wave.c[15], st.wave.c} + bias_ext;  // R7

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator iteration

   sms_step_core u_core (
      .wave_in  (st.wave),
      .dir      (step_dir),
      .shift    (st.shift),
      .wave_out (step_wave)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      next_st = st;

      // Register writes
      if (bus.wr) begin
         if (bus.addr == sms_pkg::SMS_ADDR_SIN) begin
            next_st.sin_amp = bus.wdata;  // R1
         end else if (bus.addr == sms_pkg::SMS_ADDR_COS) begin
            next_st.cos_amp = bus.wdata;  // R2
         end else if (bus.addr == sms_pkg::SMS_ADDR_SHIFT) begin
            next_st.shift = bus.wdata[3:0];  // R9
         end else if (bus.addr == sms_pkg::SMS_ADDR_BIAS) begin
            next_st.bias = bus.wdata[7:0];
         end else if (bus.addr == sms_pkg::SMS_ADDR_CTRL) begin
            next_st.ctrl = bus.wdata[7:0];
         end
      end

      // Read data stand for one cycle only, zero otherwise
      next_st.rdata = '0;
      if (bus.rd) begin
         if (bus.addr == sms_pkg::SMS_ADDR_SIN) begin
            next_st.rdata = st.sin_amp;
         end else if (bus.addr == sms_pkg::SMS_ADDR_COS) begin
            next_st.rdata = st.cos_amp;
         end else if (bus.addr == sms_pkg::SMS_ADDR_SHIFT) begin
            next_st.rdata = {12'h000, st.shift};
         end else if (bus.addr == sms_pkg::SMS_ADDR_BIAS) begin
            next_st.rdata = {8'h00, st.bias};
         end else if (bus.addr == sms_pkg::SMS_ADDR_CTRL) begin
            next_st.rdata = {8'h00, st.ctrl};
         end else if (bus.addr == sms_pkg::SMS_ADDR_WAVE_SIN) begin
            next_st.rdata = st.wave.s;
         end else if (bus.addr == sms_pkg::SMS_ADDR_WAVE_COS) begin
            next_st.rdata = st.wave.c;
         end
      end

      // Stopped oscillator tracks the programmed start amplitudes
      if (!osc_en) begin
         next_st.wave.s = clip_amp(st.sin_amp);  // R3
         next_st.wave.c = clip_amp(st.cos_amp);  // R3
      end else if (step_pulse) begin
         next_st.wave = step_wave;  // R18
      end

      // Outputs
      next_st.coil_a = '0;
      next_st.coil_b = '0;
      next_st.phase  = '0;
      if (sine_mode) begin
         next_st.coil_a = mag8(bias_s);  // R13 R15
         next_st.coil_b = mag8(bias_c);  // R13 R15
         if (sel_wave) begin
            next_st.phase = bias_s[15:6];  // R17
         end else begin
            next_st.phase = {7'h00, bias_c[16], 1'b0, bias_s[16]};  // R14
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= sms_pkg::SMS_STATE_RST;
      end else begin
         st <= next_st;
      end
   end

   assign rdata           = st.rdata;
   assign coil_a_level    = st.coil_a;
   assign coil_b_level    = st.coil_b;
   assign phase_out_lines = st.phase;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   sin_reset_a: assert property (@(posedge clk) !rst_n |=> st.sin_amp == 16'h1FFF) // R1
      else $error("sine amplitude not 1FFFh after reset");

   cos_reset_a: assert property (@(posedge clk) !rst_n |=> st.cos_amp == 16'h2FFF) // R2
      else $error("cosine amplitude not 2FFFh after reset");

   shift_reset_a: assert property (@(posedge clk) !rst_n |=> st.shift == 4'h4) // R9
      else $error("resolution shift not 4h after reset");

   amp_clip_a: assert property (@(posedge clk) disable iff (!rst_n) // R3
      (!osc_en && $signed(st.sin_amp) > $signed(16'h3FFF)) |=> st.wave.s == 16'h3FFF)
      else $error("oversized sine amplitude not limited to 3FFFh");

   wave_sat_a: assert property (@(posedge clk) disable iff (!rst_n) // R5
      osc_en |-> ($signed(st.wave.s) <= 16384 && $signed(st.wave.s) >= -16384
                  && $signed(st.wave.c) <= 16384 && $signed(st.wave.c) >= -16384))
      else $error("wave sample outside saturation limits");

   step_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // R18
      (osc_en && !step_pulse) |=> $stable(st.wave))
      else $error("oscillator moved without a step pulse");

   step_move_a: assert property (@(posedge clk) disable iff (!rst_n) // R8
      (osc_en && step_pulse && step_dir && $signed(st.wave.c) > 0)
      |=> $signed(st.wave.s) >= $signed($past(st.wave.s)))
      else $error("forward step with positive cosine lowered the sine");

   coil_off_a: assert property (@(posedge clk) disable iff (!rst_n) // R13
      !sine_mode |=> (coil_a_level == 8'h00 && coil_b_level == 8'h00))
      else $error("coil levels driven outside sine-step mode");

   phase_sign_a: assert property (@(posedge clk) disable iff (!rst_n) // R14
      (sine_mode && !sel_wave) |=> (phase_out_lines[0] == $past(bias_s[16])
                                    && phase_out_lines[2] == $past(bias_c[16])
                                    && phase_out_lines[1] == 1'b0))
      else $error("phase bits do not follow the wave signs");

   phase_wave_a: assert property (@(posedge clk) disable iff (!rst_n) // R17
      (sine_mode && sel_wave) |=> phase_out_lines == $past(bias_s[15:6]))
      else $error("phase lines do not carry the sine wave");

   bias_reset_a: assert property (@(posedge clk) !rst_n |=> st.bias == 8'h00) // R7
      else $error("offset not zero after reset");

   out_reset_a: assert property (@(posedge clk) !rst_n |=> coil_a_level == 8'h00) // R13
      else $error("coil level not zero after reset");

   sin_write_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
      (bus.wr && bus.addr == sms_pkg::SMS_ADDR_SIN) |=> st.sin_amp == $past(bus.wdata))
      else $error("sine amplitude write not taken");

   cos_write_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
      (bus.wr && bus.addr == sms_pkg::SMS_ADDR_COS) |=> st.cos_amp == $past(bus.wdata))
      else $error("cosine amplitude write not taken");

   shift_write_a: assert property (@(posedge clk) disable iff (!rst_n) // R9
      (bus.wr && bus.addr == sms_pkg::SMS_ADDR_SHIFT) |=> st.shift == $past(bus.wdata[3:0]))
      else $error("resolution shift write not taken");

   bias_write_a: assert property (@(posedge clk) disable iff (!rst_n) // R7
      (bus.wr && bus.addr == sms_pkg::SMS_ADDR_BIAS) |=> st.bias == $past(bus.wdata[7:0]))
      else $error("offset write not taken");

   sin_floor_a: assert property (@(posedge clk) disable iff (!rst_n) // R3
      (!osc_en && $signed(st.sin_amp) < $signed(16'hC001)) |=> st.wave.s == 16'hC001)
      else $error("undersized sine amplitude not limited to C001h");

   cos_clip_a: assert property (@(posedge clk) disable iff (!rst_n) // R3
      (!osc_en && $signed(st.cos_amp) > $signed(16'h3FFF)) |=> st.wave.c == 16'h3FFF)
      else $error("oversized cosine amplitude not limited to 3FFFh");

   cos_floor_a: assert property (@(posedge clk) disable iff (!rst_n) // R3
      (!osc_en && $signed(st.cos_amp) < $signed(16'hC001)) |=> st.wave.c == 16'hC001)
      else $error("undersized cosine amplitude not limited to C001h");

   amp_track_a: assert property (@(posedge clk) disable iff (!rst_n) // R3
      (!osc_en && $signed(st.sin_amp) <= $signed(16'h3FFF)
       && $signed(st.sin_amp) >= $signed(16'hC001)) |=> st.wave.s == $past(st.sin_amp))
      else $error("in-range sine amplitude not passed through");

   step_load_a: assert property (@(posedge clk) disable iff (!rst_n) // R18
      (osc_en && step_pulse) |=> st.wave == $past(step_wave))
      else $error("step pulse did not load one iteration");

   step_back_a: assert property (@(posedge clk) disable iff (!rst_n) // R8
      (osc_en && step_pulse && !step_dir && $signed(st.wave.s) > 0)
      |=> $signed(st.wave.c) >= $signed($past(st.wave.c)))
      else $error("reverse step with positive sine lowered the cosine");

   level_a_a: assert property (@(posedge clk) disable iff (!rst_n) // R13
      (sine_mode && bias_s[16:14] == 3'h0) |=> coil_a_level == $past(bias_s[13:6]))
      else $error("coil a level does not follow the sine magnitude");

   level_b_a: assert property (@(posedge clk) disable iff (!rst_n) // R13
      (sine_mode && bias_c[16:14] == 3'h0) |=> coil_b_level == $past(bias_c[13:6]))
      else $error("coil b level does not follow the cosine magnitude");

   level_full_a: assert property (@(posedge clk) disable iff (!rst_n) // R15
      (sine_mode && !bias_s[16] && bias_s[15:14] != 2'h0) |=> coil_a_level == 8'hFF)
      else $error("coil a level not held at full scale");

   phase_off_a: assert property (@(posedge clk) disable iff (!rst_n) // R14
      !sine_mode |=> phase_out_lines == 10'h000)
      else $error("phase lines driven outside sine-step mode");

   rdata_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
      !bus.rd |=> rdata == 16'h0000)
      else $error("read data present without a read strobe");

   // Reads of the live wave must show the registered sample, not the next one
   wave_read_a: assert property (@(posedge clk) disable iff (!rst_n) // R8
      (bus.rd && bus.addr == sms_pkg::SMS_ADDR_WAVE_SIN) |=> rdata == $past(st.wave.s))
      else $error("wave sine readback wrong");

endmodule // sms_microstep

//--- sms_pkg.sv
package sms_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0]  SMS_ADDR_SIN      = 8'h24;
   localparam logic [7:0]  SMS_ADDR_COS      = 8'h26;
   localparam logic [7:0]  SMS_ADDR_SHIFT    = 8'h2E;
   localparam logic [7:0]  SMS_ADDR_BIAS     = 8'h3A;
   localparam logic [7:0]  SMS_ADDR_CTRL     = 8'h3C;
   localparam logic [7:0]  SMS_ADDR_WAVE_SIN = 8'h40;
   localparam logic [7:0]  SMS_ADDR_WAVE_COS = 8'h42;

   ////////////////////////////////////////////////////////////////////////////
   // Values after reset
   localparam logic [15:0] SMS_RST_SIN       = 16'h1FFF;
   localparam logic [15:0] SMS_RST_COS       = 16'h2FFF;
   localparam logic [3:0]  SMS_RST_SHIFT     = 4'h4;
   localparam logic [7:0]  SMS_RST_BIAS      = 8'h00;
   localparam logic [7:0]  SMS_RST_CTRL      = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Amplitude and wave limits
   localparam logic [15:0] SMS_AMP_MAX       = 16'h3FFF;
   localparam logic [15:0] SMS_AMP_MIN       = 16'hC001;
   localparam logic [16:0] SMS_WAVE_POS      = 17'h04000;
   localparam logic [16:0] SMS_WAVE_NEG      = 17'h1C000;
   localparam logic [7:0]  SMS_DAC_FULL      = 8'hFF;

   ////////////////////////////////////////////////////////////////////////////
   // Control register fields
   localparam int unsigned SMS_CTRL_OSC_EN   = 0;
   localparam int unsigned SMS_CTRL_PAT_EN   = 1;
   localparam int unsigned SMS_CTRL_SEL      = 2;
   localparam int unsigned SMS_CTRL_STEP_LSB = 4;
   localparam int unsigned SMS_CTRL_MOT_LSB  = 6;
   localparam logic [1:0]  SMS_STEP_SINE     = 2'h3;
   localparam logic [1:0]  SMS_MOTOR_SINE    = 2'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } sms_bus_t;

   typedef struct packed {
      logic [15:0] s;
      logic [15:0] c;
   } sms_wave_t;

   typedef struct packed {
      logic [15:0] sin_amp;
      logic [15:0] cos_amp;
      logic [3:0]  shift;
      logic [7:0]  bias;
      logic [7:0]  ctrl;
      sms_wave_t   wave;
      logic [15:0] rdata;
      logic [7:0]  coil_a;
      logic [7:0]  coil_b;
      logic [9:0]  phase;
   } sms_state_t;

   localparam sms_state_t SMS_STATE_RST = '{sin_amp: SMS_RST_SIN,
                                            cos_amp: SMS_RST_COS,
                                            shift:   SMS_RST_SHIFT,
                                            bias:    SMS_RST_BIAS,
                                            ctrl:    SMS_RST_CTRL,
                                            default: '0};

endpackage

//--- sms_step_core.sv
`timescale 1ns/10ps
module sms_step_core (
   input  wire sms_pkg::sms_wave_t wave_in,
   input  wire logic               dir,
   input  wire logic [3:0]         shift,
   output sms_pkg::sms_wave_t      wave_out
);

   // Clip to the wave limit; values back in range pass through unchanged
   function automatic logic [15:0] sat(input logic [16:0] x);
      logic [15:0] r;
      r = x[15:0];
      if ($signed(x) > $signed(sms_pkg::SMS_WAVE_POS)) begin  // R5
         r = sms_pkg::SMS_WAVE_POS[15:0];
      end else if ($signed(x) < $signed(sms_pkg::SMS_WAVE_NEG)) begin  // R5
         r = sms_pkg::SMS_WAVE_NEG[15:0];
      end
      return r;  // R6
   endfunction

   logic signed [15:0] s_sh;
   logic signed [15:0] c_sh;
   logic signed [15:0] s_new;
   logic signed [15:0] c_new;
   logic signed [15:0] s_new_sh;
   logic signed [15:0] c_new_sh;
   logic        [16:0] s_sum;
   logic        [16:0] c_sum;

   ////////////////////////////////////////////////////////////////////////////
   // One iteration; reverse runs the same recurrence backwards, exactly while no sample saturates
   always_comb begin
      s_sh     = $signed(wave_in.s) >>> shift;  // R8 R10 R11
      c_sh     = $signed(wave_in.c) >>> shift;
      s_sum    = '0;
      c_sum    = '0;
      s_new    = '0;
      c_new    = '0;
      s_new_sh = '0;
      c_new_sh = '0;
      if (dir) begin
         // Extra bit so an excursion past the limit is seen
         s_sum    = {wave_in.s[15], wave_in.s} + {c_sh[15], c_sh};  // R4 R8
         s_new    = $signed(sat(s_sum));
         s_new_sh = s_new >>> shift;
         c_sum    = {wave_in.c[15], wave_in.c} - {s_new_sh[15], s_new_sh};  // R4 R8
         c_new    = $signed(sat(c_sum));
      end else begin
         c_sum    = {wave_in.c[15], wave_in.c} + {s_sh[15], s_sh};  // R4 R18
         c_new    = $signed(sat(c_sum));
         c_new_sh = c_new >>> shift;
         s_sum    = {wave_in.s[15], wave_in.s} - {c_new_sh[15], c_new_sh};  // R4 R18
         s_new    = $signed(sat(s_sum));
      end
      wave_out.s = s_new;
      wave_out.c = c_new;
   end

endmodule // sms_step_core

//--- sms_stage_model.sv
`timescale 1ns/10ps
module sms_stage_model (
   input  wire logic [7:0]  coil_a_level,
   input  wire logic [7:0]  coil_b_level,
   input  wire logic [9:0]  phase_out_lines,
   output logic signed [8:0] current_a,
   output logic signed [8:0] current_b
);
   // Signed coil current: magnitude from level, polarity line 0 reverses coil a, line 2 coil b
   assign current_a = phase_out_lines[0] ? -$signed({1'b0, coil_a_level})
                                         : $signed({1'b0, coil_a_level});
   assign current_b = phase_out_lines[2] ? -$signed({1'b0, coil_b_level})
                                         : $signed({1'b0, coil_b_level});
endmodule // sms_stage_model

//--- testbench.sv
`timescale 1ns/10ps
module testbench;
   logic              clk;
   logic              rst_n;
   sms_pkg::sms_bus_t bus;
   logic              step_pulse;
   logic              step_dir;
   logic [15:0]       rdata;
   logic [7:0]        coil_a_level;
   logic [7:0]        coil_b_level;
   logic [9:0]        phase_out_lines;
   logic signed [8:0] current_a;
   logic signed [8:0] current_b;
   int                err_total;
   int                total_checks;
   int                s, c, k, bias;
   logic              sel, osc, mode;
   logic [15:0]       d;
   logic [43:0]       corner [7];

   sms_microstep sms_microstep_inst (.clk(clk), .rst_n(rst_n), .bus(bus),
      .step_pulse(step_pulse), .step_dir(step_dir), .rdata(rdata),
      .coil_a_level(coil_a_level), .coil_b_level(coil_b_level),
      .phase_out_lines(phase_out_lines));
   sms_stage_model sms_stage_model_inst (.coil_a_level(coil_a_level),
      .coil_b_level(coil_b_level), .phase_out_lines(phase_out_lines),
      .current_a(current_a), .current_b(current_b));

   always #5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   function automatic int sat(int v);
      return (v > 16384) ? 16384 : ((v < -16384) ? -16384 : v);
   endfunction
   function automatic int clipa(logic [15:0] a);
      int v;
      v = int'($signed(a));
      return (v > 16383) ? 16383 : ((v < -16383) ? -16383 : v);
   endfunction
   function automatic logic [7:0] lvl(int b);
      int m;
      m = ((b < 0) ? -b : b) >>> 6;
      return (m > 255) ? 8'hFF : m[7:0];
   endfunction
   function automatic logic [25:0] outs();
      int bs, bc;
      bs = s + bias * 64;
      bc = c + bias * 64;
      if (!mode) return 26'h0;
      return {lvl(bs), lvl(bc), sel ? bs[15:6] : {7'h0, bc < 0, 1'b0, bs < 0}};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk_reg(logic [15:0] g, logic [15:0] e);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_out(logic [25:0] g, logic [25:0] e);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("Error at %0t: outputs %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [15:0] v);
      @(posedge clk);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rdchk(logic [7:0] a, logic [15:0] e);
      @(posedge clk);
      bus <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 chk_reg(rdata, e);
   endtask
   // Steps are ignored while the oscillator is off
   task automatic adv(logic dn);
      if (!osc) return;
      if (dn) begin
         s = sat(s + (c >>> k));
         c = sat(c - (s >>> k));
      end else begin
         c = sat(c + (s >>> k));
         s = sat(s - (c >>> k));
      end
   endtask
   task automatic step(logic dn);
      @(posedge clk);
      step_pulse <= 1'b1;
      step_dir   <= dn;
      @(posedge clk);
      step_pulse <= 1'b0;
      adv(dn);
      @(posedge clk);
      #1 chk_out({coil_a_level, coil_b_level, phase_out_lines}, outs());
      rdchk(sms_pkg::SMS_ADDR_WAVE_SIN, 16'(s));
      rdchk(sms_pkg::SMS_ADDR_WAVE_COS, 16'(c));
   endtask
   task automatic run(logic [43:0] t, int b);
      wr(sms_pkg::SMS_ADDR_CTRL, 16'h0);
      wr(sms_pkg::SMS_ADDR_SIN, t[43:28]);
      wr(sms_pkg::SMS_ADDR_COS, t[27:12]);
      wr(sms_pkg::SMS_ADDR_SHIFT, {12'h0, t[11:8]});
      wr(sms_pkg::SMS_ADDR_BIAS, 16'(b));
      wr(sms_pkg::SMS_ADDR_CTRL, {8'h0, t[7:0]});
      s = clipa(t[43:28]);
      c = clipa(t[27:12]);
      k = t[11:8];
      bias = b;
      sel = t[2];
      osc = t[0];
      mode = t[0] & !t[1] & (t[5:4] == 2'h3) & (t[7:6] == 2'h0);
      rdchk(sms_pkg::SMS_ADDR_SHIFT, {12'h0, t[11:8]});
      rdchk(sms_pkg::SMS_ADDR_BIAS, 16'(b));
      rdchk(sms_pkg::SMS_ADDR_WAVE_SIN, 16'(s));
      rdchk(sms_pkg::SMS_ADDR_WAVE_COS, 16'(c));
      repeat (24) step(1'($urandom_range(0, 1)));
      // Back-to-back pulses, one per cycle
      @(posedge clk);
      step_pulse <= 1'b1;
      step_dir   <= 1'b1;
      repeat (8) @(posedge clk);
      step_pulse <= 1'b0;
      repeat (8) adv(1'b1);
      rdchk(sms_pkg::SMS_ADDR_WAVE_SIN, 16'(s));
      rdchk(sms_pkg::SMS_ADDR_WAVE_COS, 16'(c));
   endtask
   task automatic test_done;
      $display("Checks %0d, mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #1000000;
      err_total++;
      test_done;
   end

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      bus = '0;
      step_pulse = 1'b0;
      step_dir = 1'b0;
      err_total = 0;
      total_checks = 0;
      mode = 1'b0;
      // Overflow, clip, linear, constant, and three outside the mode
      corner = '{44'h7FFFC000131, 44'h3FFF3FFF035, 44'h00030000131, 44'h00010000135,
                 44'h10002000233, 44'h10002000271, 44'h10002000230};
      void'($urandom(32'h1988));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rdchk(sms_pkg::SMS_ADDR_SIN, 16'h1FFF);
      rdchk(sms_pkg::SMS_ADDR_COS, 16'h2FFF);
      rdchk(sms_pkg::SMS_ADDR_SHIFT, 16'h0004);
      rdchk(sms_pkg::SMS_ADDR_WAVE_COS, 16'h2FFF);
      wr(8'h50, 16'hA5A5);
      rdchk(8'h50, 16'h0000);
      chk_out({coil_a_level, coil_b_level, phase_out_lines}, 26'h0);
      foreach (corner[i]) run(corner[i], $urandom_range(0, 12));
      for (int i = 0; i < 6; i++) begin
         // Amplitudes kept small so the squared sum stays in range
         run({16'($urandom_range(0, 22000) - 11000), 16'($urandom_range(0, 22000) - 11000),
              4'($urandom_range(1, 6)), $urandom_range(0, 1) ? 8'h35 : 8'h31},
             $urandom_range(0, 12));
      end
      test_done;
   end
endmodule // testbench
